/* atarsc_regs.svh */
// Task-file offsets, bit positions, opcodes and counts for the read block.
// Included by both ends; holds definitions only.
`ifndef ATARSC_REGS_SVH
`define ATARSC_REGS_SVH

// Task-file offsets on tf_addr
`define ATARSC_A_DATA     4'h0
`define ATARSC_A_ERROR    4'h1
`define ATARSC_A_COUNT    4'h2
`define ATARSC_A_LBA_LO   4'h3
`define ATARSC_A_LBA_MID  4'h4
`define ATARSC_A_LBA_HI   4'h5
`define ATARSC_A_DEVHEAD  4'h6
`define ATARSC_A_CMD      4'h7
`define ATARSC_A_DEVCTL   4'h8

// Field positions
`define ATARSC_ST_BSY     7
`define ATARSC_ST_DRDY    6
`define ATARSC_ST_DF      5
`define ATARSC_ST_DRQ     3
`define ATARSC_ST_ERR     0
`define ATARSC_DH_LBA     6
`define ATARSC_DH_DEV     4
`define ATARSC_DC_HOB     7
`define ATARSC_ER_ABRT    2
`define ATARSC_ER_UNC     6

// Opcodes
`define ATARSC_OP_NMAX28  8'hF8
`define ATARSC_OP_NMAX48  8'h27
`define ATARSC_OP_RD28    8'h20
`define ATARSC_OP_RD48    8'h24

// Reset values and counts
`define ATARSC_DH_RST     8'hA0
`define ATARSC_LAST_WORD  8'hFF
`define ATARSC_MAX28      17'h00100
`define ATARSC_MAX48      17'h10000
`define ATARSC_FIFO_DEPTH 32

`endif

/* atarsc_pkg.sv */
// Types shared by both ends of the sector read block.
// Assumes atarsc_regs.svh for numeric constants.
package atarsc_pkg;
  typedef enum logic [1:0] {
    DEV_IDLE, DEV_NMAX, DEV_FILL, DEV_XFER
  } atarsc_dev_state_t;

  typedef enum logic [2:0] {
    HST_IDLE, HST_WR, HST_WAIT, HST_STAT, HST_DATA, HST_MAX
  } atarsc_hst_state_t;
endpackage

/* atarsc_if.sv */
// Task-file link between host controller and storage device.
// Both ends run on the same core_clk; all signals are plain levels.
`timescale 1ns/1ps
interface atarsc_if;
  logic [3:0]  tf_addr;
  logic [7:0]  tf_wdata;
  logic        tf_wr;
  logic        tf_rd;
  logic [15:0] tf_rdata;
  logic        tf_rvalid;
  logic        intrq;

  modport device (
    input  tf_addr, tf_wdata, tf_wr, tf_rd,
    output tf_rdata, tf_rvalid, intrq
  );
  modport host (
    output tf_addr, tf_wdata, tf_wr, tf_rd,
    input  tf_rdata, tf_rvalid, intrq
  );
endinterface

/* atarsc_device.sv */
// Storage-device end: task-file registers, native-max queries and
// PIO sector reads through a media FIFO into a sector buffer.
// Assumes one clock shared with the host and a media source on the user side.
// Summary of operation
// - F8h returns native max as 28-bit LBA
// - 27h returns native max as 48-bit LBA
// - Host sets LBA bit for max queries
// - Host picks target with device select bit
// - 28-bit result spans head and address bytes
// - 48-bit result spans three 16-bit registers
// - High byte select picks readout half
// - 20h reads count sectors, zero means 256
// - 28-bit read starts at programmed address
// - Busy, fill buffer, request data, interrupt
// - Host reads 512 bytes per interrupt
// - 28-bit error stops, keeps failing address
// - 24h reads count sectors, zero means 65536
// - 48-bit completion leaves last sector address
// - 48-bit error stops, keeps failing address
`timescale 1ns/1ps
`include "atarsc_regs.svh"

module atarsc_fifo #(
  parameter int W = 17,
  parameter int D = 32
) (
  input  wire logic         core_clk,
  input  wire logic         sys_rst,
  input  wire logic         in_valid,
  input  wire logic [W-1:0] in_data,
  output      logic         in_ready,
  output      logic         out_valid,
  output      logic [W-1:0] out_data,
  input  wire logic         out_ready
);
  // Pointers wrap naturally, so D must be a power of two
  localparam int AW = $clog2(D);
  logic [W-1:0]  mem [0:D-1];
  logic [AW-1:0] wp;
  logic [AW-1:0] rp;
  logic [AW:0]   cnt;
  logic [AW:0]   next_cnt;
  wire           push = in_valid && in_ready;
  wire           pop  = out_valid && out_ready;

  always_comb begin
    next_cnt = cnt + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      cnt       <= '0;
      wp        <= '0;
      rp        <= '0;
      in_ready  <= 1'b1;
      out_valid <= 1'b0;
    end else begin
      cnt       <= next_cnt;
      wp        <= wp + {{(AW-1){1'b0}}, push};
      rp        <= rp + {{(AW-1){1'b0}}, pop};
      in_ready  <= next_cnt != (AW+1)'(D);
      out_valid <= next_cnt != '0;
    end
  end

  always_ff @(posedge core_clk) begin
    if (push) begin
      mem[wp] <= in_data;
    end
  end

  assign out_data = mem[rp];
endmodule

module atarsc_device #(
  parameter logic DEV_SEL = 1'b0
) (
  input  wire logic        core_clk,
  input  wire logic        sys_rst,
  atarsc_if.device         tf,
  input  wire logic [47:0] native_max,
  input  wire logic        media_valid,
  input  wire logic [15:0] media_data,
  input  wire logic        media_err,
  output      logic        media_ready,
  output      logic        media_req,
  output      logic [47:0] media_lba
);
  atarsc_pkg::atarsc_dev_state_t state;
  logic [47:0] lba;
  logic [15:0] cnt;
  logic [7:0]  devhead;
  logic        high_byte_select;
  logic [7:0]  err_code;
  logic        busy;
  logic        data_request_flag;
  logic        err;
  logic        ext;
  logic        sec_err;
  logic [16:0] remaining;
  logic [7:0]  wptr;
  logic [7:0]  rptr;
  logic [15:0] sbuf [0:255];
  logic        f_valid;
  logic [16:0] f_data;
  logic [7:0]  status;

  // Task-file writes other than device control are dropped while busy or a sector is pending
  wire wr_ok    = tf.tf_wr && !busy && !data_request_flag;
  wire devheadsel_ok = devhead[`ATARSC_DH_DEV] == DEV_SEL;
  wire cmd_go   = wr_ok && tf.tf_addr == `ATARSC_A_CMD
                  && devheadsel_ok;
  wire is_nmax  = tf.tf_wdata == `ATARSC_OP_NMAX28
                  || tf.tf_wdata == `ATARSC_OP_NMAX48;
  wire nmax_ok  = is_nmax && devhead[`ATARSC_DH_LBA];
  wire is_rd28  = tf.tf_wdata == `ATARSC_OP_RD28;
  wire is_rd48  = tf.tf_wdata == `ATARSC_OP_RD48;
  wire abort    = cmd_go && !nmax_ok && !is_rd28 && !is_rd48;
  wire f_ready  = state == atarsc_pkg::DEV_FILL;
  wire fill_w   = f_valid && f_ready;
  wire fill_end = fill_w && wptr == `ATARSC_LAST_WORD;
  wire data_rd  = tf.tf_rd && tf.tf_addr == `ATARSC_A_DATA
                  && state == atarsc_pkg::DEV_XFER;
  wire sect_end = data_rd && rptr == `ATARSC_LAST_WORD;
  wire more     = !err && remaining != 17'h00001;
  wire [47:0] inc48 = lba + 48'h1;
  wire [27:0] inc28 = {devhead[3:0], lba[23:0]} + 28'h1;
  wire [47:0] next_lba = ext ? inc48 : {20'h0, inc28};
  wire [47:0] cur28 = {20'h0, devhead[3:0], lba[23:0]};

  assign status = {busy, 1'b1, 1'b0, 1'b0, data_request_flag, 2'b00, err};

  atarsc_fifo #(.W(17), .D(`ATARSC_FIFO_DEPTH)) u_fifo (
    .core_clk  (core_clk),
    .sys_rst   (sys_rst),
    .in_valid  (media_valid),
    .in_data   ({media_err, media_data}),
    .in_ready  (media_ready),
    .out_valid (f_valid),
    .out_data  (f_data),
    .out_ready (f_ready)
  );

  // Command sequencing
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      state     <= atarsc_pkg::DEV_IDLE;
      busy      <= 1'b0;
      data_request_flag       <= 1'b0;
      err       <= 1'b0;
      err_code  <= 8'h00;
      ext       <= 1'b0;
      sec_err   <= 1'b0;
      remaining <= 17'h00000;
      wptr      <= 8'h00;
      rptr      <= 8'h00;
      media_req <= 1'b0;
      media_lba <= 48'h0;
    end else begin
      media_req <= 1'b0;
      case (state)
        atarsc_pkg::DEV_IDLE: begin
          if (cmd_go) begin
            err      <= abort;
            err_code <= abort ? 8'h04 : 8'h00;
            ext      <= is_rd48 || tf.tf_wdata == `ATARSC_OP_NMAX48;
            sec_err  <= 1'b0;
            wptr     <= 8'h00;
            rptr     <= 8'h00;
            if (nmax_ok) begin
              busy  <= 1'b1;
              state <= atarsc_pkg::DEV_NMAX;
            end else if (is_rd28 || is_rd48) begin
              busy      <= 1'b1;
              state     <= atarsc_pkg::DEV_FILL;
              media_req <= 1'b1;
              if (is_rd48) begin
                remaining <= (cnt == 16'h0000) ? `ATARSC_MAX48
                             : {1'b0, cnt};
                media_lba <= lba;
              end else begin
                remaining <= (cnt[7:0] == 8'h00) ? `ATARSC_MAX28
                             : {9'h000, cnt[7:0]};
                media_lba <= cur28;
              end
            end
          end
        end
        atarsc_pkg::DEV_NMAX: begin
          busy  <= 1'b0;
          state <= atarsc_pkg::DEV_IDLE;
        end
        atarsc_pkg::DEV_FILL: begin
          if (fill_w) begin
            wptr    <= wptr + 8'h01;
            sec_err <= sec_err | f_data[16];
          end
          if (fill_end) begin
            busy  <= 1'b0;
            data_request_flag   <= 1'b1;
            err   <= sec_err | f_data[16];
            err_code <= (sec_err | f_data[16]) ? 8'h40 : 8'h00;
            state <= atarsc_pkg::DEV_XFER;
          end
        end
        atarsc_pkg::DEV_XFER: begin
          if (data_rd) begin
            rptr <= rptr + 8'h01;
          end
          if (sect_end) begin
            data_request_flag <= 1'b0;
            // Failing sector ends the command with its address kept
            if (more) begin
              remaining <= remaining - 17'h00001;
              busy      <= 1'b1;
              wptr      <= 8'h00;
              sec_err   <= 1'b0;
              media_req <= 1'b1;
              media_lba <= next_lba;
              state     <= atarsc_pkg::DEV_FILL;
            end else begin
              state <= atarsc_pkg::DEV_IDLE;
            end
          end
        end
        default: state <= atarsc_pkg::DEV_IDLE;
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (fill_w) begin
      sbuf[wptr] <= f_data[15:0];
    end
  end

  // Address bytes shift on write; upper half holds the earlier byte
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      lba <= 48'h0;
    end else if (state == atarsc_pkg::DEV_NMAX) begin
      lba <= ext ? native_max : {24'h0, native_max[23:0]};
    end else if (sect_end && more) begin
      lba <= ext ? inc48 : {lba[47:24], inc28[23:0]};
    end else if (wr_ok) begin
      case (tf.tf_addr)
        `ATARSC_A_LBA_LO:  lba <= {lba[47:32], lba[7:0], lba[23:8],
                                   tf.tf_wdata};
        `ATARSC_A_LBA_MID: lba <= {lba[47:40], lba[15:8], lba[31:16],
                                   tf.tf_wdata, lba[7:0]};
        `ATARSC_A_LBA_HI:  lba <= {lba[23:16], lba[39:24],
                                   tf.tf_wdata, lba[15:0]};
        default:           lba <= lba;
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      cnt <= 16'h0000;
    end else if (wr_ok && tf.tf_addr == `ATARSC_A_COUNT) begin
      cnt <= {cnt[7:0], tf.tf_wdata};
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      devhead <= `ATARSC_DH_RST;
    end else if (state == atarsc_pkg::DEV_NMAX && !ext) begin
      devhead <= {devhead[7:4], native_max[27:24]};
    end else if (sect_end && more && !ext) begin
      devhead <= {devhead[7:4], inc28[27:24]};
    end else if (wr_ok && tf.tf_addr == `ATARSC_A_DEVHEAD) begin
      devhead <= tf.tf_wdata;
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      high_byte_select <= 1'b0;
    end else if (tf.tf_wr && tf.tf_addr == `ATARSC_A_DEVCTL) begin
      high_byte_select <= tf.tf_wdata[`ATARSC_DC_HOB];
    end
  end

  // Read answers one cycle after the strobe
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      tf.tf_rdata  <= 16'h0000;
      tf.tf_rvalid <= 1'b0;
    end else begin
      tf.tf_rvalid <= tf.tf_rd;
      case (tf.tf_addr)
        `ATARSC_A_DATA:    tf.tf_rdata <= data_rd ? sbuf[rptr] : 16'h0000;
        `ATARSC_A_ERROR:   tf.tf_rdata <= {8'h00, err_code};
        `ATARSC_A_COUNT:   tf.tf_rdata <= {8'h00, high_byte_select ? cnt[15:8] : cnt[7:0]};
        `ATARSC_A_LBA_LO:  tf.tf_rdata <= {8'h00,
                             high_byte_select ? lba[31:24] : lba[7:0]};
        `ATARSC_A_LBA_MID: tf.tf_rdata <= {8'h00,
                             high_byte_select ? lba[39:32] : lba[15:8]};
        `ATARSC_A_LBA_HI:  tf.tf_rdata <= {8'h00,
                             high_byte_select ? lba[47:40] : lba[23:16]};
        `ATARSC_A_DEVHEAD: tf.tf_rdata <= {8'h00, devhead};
        `ATARSC_A_CMD:     tf.tf_rdata <= {8'h00, status};
        `ATARSC_A_DEVCTL:  tf.tf_rdata <= {8'h00, status};
        default:           tf.tf_rdata <= 16'h0000;
      endcase
    end
  end

  // A new event beats a status read landing in the same cycle
  wire irq_set = state == atarsc_pkg::DEV_NMAX || fill_end || abort;
  wire irq_clr = tf.tf_rd && tf.tf_addr == `ATARSC_A_CMD;
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      tf.intrq <= 1'b0;
    end else begin
      tf.intrq <= irq_set || (tf.intrq && !irq_clr);
    end
  end
endmodule

/* atarsc_host.sv */
// Host-controller end: programs the task file, issues a command, then
// collects status, sector words or the native max address.
// Assumes the device end on the same core_clk behind atarsc_if.
`timescale 1ns/1ps
`include "atarsc_regs.svh"

module atarsc_host (
  input  wire logic        core_clk,
  input  wire logic        sys_rst,
  atarsc_if.host           tf,
  input  wire logic        cmd_valid,
  input  wire logic [7:0]  cmd_op,
  input  wire logic [47:0] cmd_lba,
  input  wire logic [15:0] cmd_count,
  input  wire logic        cmd_dev,
  output      logic        cmd_ready,
  output      logic [15:0] data_out,
  output      logic        data_valid,
  output      logic        done,
  output      logic [7:0]  done_status,
  output      logic [47:0] result_lba
);
  atarsc_pkg::atarsc_hst_state_t state;
  logic [7:0]  c_op;
  logic [47:0] c_lba;
  logic [15:0] c_cnt;
  logic        c_dev;
  logic [3:0]  step;
  logic [8:0]  words;
  logic [16:0] left;
  logic        pend;
  logic        err_seen;
  logic [3:0]  w_addr;
  logic [7:0]  w_data;
  logic [3:0]  r_addr;

  wire ext  = c_op == `ATARSC_OP_RD48 || c_op == `ATARSC_OP_NMAX48;
  wire nmax = c_op == `ATARSC_OP_NMAX28 || c_op == `ATARSC_OP_NMAX48;

  // Each register gets its earlier byte first, then the lower one
  always_comb begin
    w_addr = `ATARSC_A_DEVCTL;
    w_data = 8'h00;
    case (step)
      4'h1: begin w_addr = `ATARSC_A_COUNT;   w_data = c_cnt[15:8]; end
      4'h2: begin w_addr = `ATARSC_A_COUNT;   w_data = c_cnt[7:0]; end
      4'h3: begin w_addr = `ATARSC_A_LBA_LO;  w_data = c_lba[31:24]; end
      4'h4: begin w_addr = `ATARSC_A_LBA_LO;  w_data = c_lba[7:0]; end
      4'h5: begin w_addr = `ATARSC_A_LBA_MID; w_data = c_lba[39:32]; end
      4'h6: begin w_addr = `ATARSC_A_LBA_MID; w_data = c_lba[15:8]; end
      4'h7: begin w_addr = `ATARSC_A_LBA_HI;  w_data = c_lba[47:40]; end
      4'h8: begin w_addr = `ATARSC_A_LBA_HI;  w_data = c_lba[23:16]; end
      4'h9: begin
        w_addr = `ATARSC_A_DEVHEAD;
        // LBA mode always on; device chosen by c_dev
        w_data = {3'b111, c_dev, ext ? 4'h0 : c_lba[27:24]};
      end
      4'hA: begin w_addr = `ATARSC_A_CMD;     w_data = c_op; end
      default: begin w_addr = `ATARSC_A_DEVCTL; w_data = 8'h00; end
    endcase
  end

  // Native max readout order: low half, then high half under HIGH_BYTE_SELECT
  always_comb begin
    case (step)
      4'h0, 4'h5: r_addr = `ATARSC_A_LBA_LO;
      4'h1, 4'h6: r_addr = `ATARSC_A_LBA_MID;
      4'h2, 4'h7: r_addr = `ATARSC_A_LBA_HI;
      default:    r_addr = `ATARSC_A_DEVHEAD;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      state       <= atarsc_pkg::HST_IDLE;
      c_op        <= 8'h00;
      c_lba       <= 48'h0;
      c_cnt       <= 16'h0000;
      c_dev       <= 1'b0;
      step        <= 4'h0;
      words       <= 9'h000;
      left        <= 17'h00000;
      pend        <= 1'b0;
      err_seen    <= 1'b0;
      cmd_ready   <= 1'b1;
      data_out    <= 16'h0000;
      data_valid  <= 1'b0;
      done        <= 1'b0;
      done_status <= 8'h00;
      result_lba  <= 48'h0;
      tf.tf_addr  <= 4'h0;
      tf.tf_wdata <= 8'h00;
      tf.tf_wr    <= 1'b0;
      tf.tf_rd    <= 1'b0;
    end else begin
      tf.tf_wr   <= 1'b0;
      tf.tf_rd   <= 1'b0;
      data_valid <= 1'b0;
      done       <= 1'b0;
      case (state)
        atarsc_pkg::HST_IDLE: begin
          if (cmd_valid) begin
            c_op      <= cmd_op;
            c_lba     <= cmd_lba;
            c_cnt     <= cmd_count;
            c_dev     <= cmd_dev;
            step      <= 4'h0;
            cmd_ready <= 1'b0;
            err_seen  <= 1'b0;
            state     <= atarsc_pkg::HST_WR;
          end
        end
        atarsc_pkg::HST_WR: begin
          tf.tf_wr    <= 1'b1;
          tf.tf_addr  <= w_addr;
          tf.tf_wdata <= w_data;
          step        <= step + 4'h1;
          if (step == 4'hA) begin
            left  <= (c_op == `ATARSC_OP_RD48)
                     ? ((c_cnt == 16'h0000) ? `ATARSC_MAX48 : {1'b0, c_cnt})
                     : ((c_cnt[7:0] == 8'h00) ? `ATARSC_MAX28
                        : {9'h000, c_cnt[7:0]});
            state <= atarsc_pkg::HST_WAIT;
          end
        end
        atarsc_pkg::HST_WAIT: begin
          if (tf.intrq && !tf.tf_wr) begin
            tf.tf_rd   <= 1'b1;
            tf.tf_addr <= `ATARSC_A_CMD;
            state      <= atarsc_pkg::HST_STAT;
          end
        end
        atarsc_pkg::HST_STAT: begin
          if (tf.tf_rvalid) begin
            done_status <= tf.tf_rdata[7:0];
            err_seen    <= tf.tf_rdata[`ATARSC_ST_ERR];
            step        <= 4'h0;
            words       <= 9'h000;
            pend        <= 1'b0;
            if (tf.tf_rdata[`ATARSC_ST_DRQ]) begin
              state <= atarsc_pkg::HST_DATA;
            end else if (nmax && !tf.tf_rdata[`ATARSC_ST_ERR]) begin
              state <= atarsc_pkg::HST_MAX;
            end else begin
              done      <= 1'b1;
              cmd_ready <= 1'b1;
              state     <= atarsc_pkg::HST_IDLE;
            end
          end
        end
        atarsc_pkg::HST_DATA: begin
          if (!pend) begin
            tf.tf_rd   <= 1'b1;
            tf.tf_addr <= `ATARSC_A_DATA;
            pend       <= 1'b1;
          end else if (tf.tf_rvalid) begin
            pend       <= 1'b0;
            data_out   <= tf.tf_rdata;
            data_valid <= 1'b1;
            words      <= words + 9'h001;
            // One whole sector per interrupt
            if (words == 9'h0FF) begin
              if (err_seen || left == 17'h00001) begin
                done      <= 1'b1;
                cmd_ready <= 1'b1;
                state     <= atarsc_pkg::HST_IDLE;
              end else begin
                left  <= left - 17'h00001;
                state <= atarsc_pkg::HST_WAIT;
              end
            end
          end
        end
        atarsc_pkg::HST_MAX: begin
          if (step == 4'h4) begin
            tf.tf_wr    <= 1'b1;
            tf.tf_addr  <= `ATARSC_A_DEVCTL;
            tf.tf_wdata <= 8'h80;
            step        <= 4'h5;
          end else if (!pend) begin
            tf.tf_rd   <= 1'b1;
            tf.tf_addr <= r_addr;
            pend       <= 1'b1;
          end else if (tf.tf_rvalid) begin
            pend <= 1'b0;
            step <= step + 4'h1;
            case (step)
              4'h0: result_lba[7:0]   <= tf.tf_rdata[7:0];
              4'h1: result_lba[15:8]  <= tf.tf_rdata[7:0];
              4'h2: result_lba[23:16] <= tf.tf_rdata[7:0];
              4'h3: result_lba[47:24] <= ext ? 24'h0
                                         : {20'h0, tf.tf_rdata[3:0]};
              4'h5: result_lba[31:24] <= tf.tf_rdata[7:0];
              4'h6: result_lba[39:32] <= tf.tf_rdata[7:0];
              default: result_lba[47:40] <= tf.tf_rdata[7:0];
            endcase
            if (step == 4'h7 || (step == 4'h3 && !ext)) begin
              done      <= 1'b1;
              cmd_ready <= 1'b1;
              state     <= atarsc_pkg::HST_IDLE;
            end
          end
        end
        default: state <= atarsc_pkg::HST_IDLE;
      endcase
    end
  end
endmodule

/* atarsc_checker.sv */
// Assertions on the task-file link joining host and device ends.
// Assumes one clock core_clk and a sync active-high sys_rst.
`timescale 1ns/1ps
`include "atarsc_regs.svh"
module atarsc_checker (
  input wire logic        core_clk,
  input wire logic        sys_rst,
  input wire logic [3:0]  tf_addr,
  input wire logic [7:0]  tf_wdata,
  input wire logic        tf_wr,
  input wire logic        tf_rd,
  input wire logic [15:0] tf_rdata,
  input wire logic        tf_rvalid,
  input wire logic        intrq
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  wire cmd_wr = tf_wr && tf_addr == `ATARSC_A_CMD;
  wire st_rd  = tf_rd && tf_addr == `ATARSC_A_CMD;
  wire nmax   = cmd_wr && (tf_wdata == `ATARSC_OP_NMAX28 ||
                           tf_wdata == `ATARSC_OP_NMAX48);
  wire rdcmd  = cmd_wr && (tf_wdata == `ATARSC_OP_RD28 ||
                           tf_wdata == `ATARSC_OP_RD48);
  sequence s_max_done;
    !intrq ##1 intrq;
  endsequence
  // A whole sector cannot arrive in under 256 cycles
  sequence s_fill;
    !intrq throughout (1'b1 ##255 1'b1);
  endsequence
  property p_max; nmax |=> s_max_done; endproperty
  property p_fill; rdcmd |=> s_fill ##[1:900] intrq; endproperty
  property p_rvl; tf_rd |=> tf_rvalid; endproperty
  property p_sil; tf_rvalid |-> $past(tf_rd); endproperty
  property p_icl; st_rd |=> !intrq; endproperty
  property p_ihd; intrq && !st_rd |=> intrq; endproperty
  property p_stat; st_rd |=> tf_rdata[6:5] == 2'b10; endproperty
  property p_byte;
    tf_rd && tf_addr != `ATARSC_A_DATA |=> tf_rdata[15:8] == 8'h00;
  endproperty
  property p_head;
    tf_rd && tf_addr == `ATARSC_A_DEVHEAD |=> tf_rdata[7] && tf_rdata[5];
  endproperty
  a_max: assert property (p_max)
    else $error("native max answer out of time");
  a_fill: assert property (p_fill)
    else $error("sector fill interrupt out of time");
  a_rvl: assert property (p_rvl)
    else $error("read not answered next cycle");
  a_sil: assert property (p_sil)
    else $error("read valid without a read");
  a_icl: assert property (p_icl)
    else $error("status read left interrupt up");
  a_ihd: assert property (p_ihd)
    else $error("interrupt dropped without status read");
  a_stat: assert property (p_stat)
    else $error("status ready or fault bit wrong");
  a_byte: assert property (p_byte)
    else $error("register read upper byte not zero");
  a_head: assert property (p_head)
    else $error("drive head fixed bits wrong");
endmodule

/* ata_read_sector_commands_tb_top.sv */
// Bench: host and device ends face to face with a random media source.
// Assumes the design files and atarsc_checker.sv compiled first.
`timescale 1ns/1ps
`include "atarsc_regs.svh"
module ata_read_sector_commands_tb_top;
  logic        core_clk;
  logic        sys_rst;
  logic        cmd_valid;
  logic [7:0]  cmd_op;
  logic [47:0] cmd_lba;
  logic [15:0] cmd_count;
  logic [47:0] native_max;
  logic [47:0] base;
  logic        media_valid;
  logic [15:0] media_data;
  logic        media_err;
  logic        media_ready;
  logic        media_req;
  logic [47:0] media_lba;
  logic        cmd_ready;
  logic [15:0] data_out;
  logic        data_valid;
  logic        done;
  logic [7:0]  done_status;
  logic [47:0] result_lba;
  logic [16:0] mq[$];
  int          n_fail;
  int          n_checks;
  int          seed;
  int          nsec;
  int          nword;
  int          err_idx;
  atarsc_if bus ();
  atarsc_device i_atarsc_device (
    .core_clk(core_clk), .sys_rst(sys_rst), .tf(bus),
    .native_max(native_max), .media_valid(media_valid),
    .media_data(media_data), .media_err(media_err),
    .media_ready(media_ready), .media_req(media_req),
    .media_lba(media_lba));
  atarsc_host i_atarsc_host (
    .core_clk(core_clk), .sys_rst(sys_rst), .tf(bus),
    .cmd_valid(cmd_valid), .cmd_op(cmd_op), .cmd_lba(cmd_lba),
    .cmd_count(cmd_count), .cmd_dev(1'b0), .cmd_ready(cmd_ready),
    .data_out(data_out), .data_valid(data_valid), .done(done),
    .done_status(done_status), .result_lba(result_lba));
  atarsc_checker i_atarsc_checker (
    .core_clk(core_clk), .sys_rst(sys_rst), .tf_addr(bus.tf_addr),
    .tf_wdata(bus.tf_wdata), .tf_wr(bus.tf_wr), .tf_rd(bus.tf_rd),
    .tf_rdata(bus.tf_rdata), .tf_rvalid(bus.tf_rvalid),
    .intrq(bus.intrq));
  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end
  task automatic bad(input string m);
    $display("BAD %0t %s", $time, m);
    n_fail++;
  endtask
  function automatic bit ck(input bit mis);
    n_checks++;
    return mis;
  endfunction
  // Word i of sector at lba is its low 16 address bits plus i
  function automatic logic [15:0] wexp(input int w);
    return 16'(base + w / 256 + w % 256);
  endfunction
  always @(posedge core_clk) begin
    if (media_valid && media_ready)
      void'(mq.pop_front());
    if (media_req) begin
      if (ck(media_lba !== base + nsec)) bad("media address");
      for (int i = 0; i < 256; i++)
        mq.push_back({nsec == err_idx && i == 5, 16'(media_lba + i)});
      nsec++;
    end
    // Offer held until taken; idle data is inverted so it never matches
    if (!(media_valid && !media_ready)) begin
      media_valid <= mq.size() > 0 && ($random(seed) & 3) != 0;
      {media_err, media_data} <= mq.size() > 0 ? mq[0]
                                 : ~{media_err, media_data};
    end
    if (data_valid) begin
      if (ck(data_out !== wexp(nword))) bad("sector word");
      nword++;
    end
  end
  task automatic run(input logic [7:0] op, input logic [15:0] cnt,
                     input int eidx, input int nexp);
    int t;
    t = 0;
    base = 48'({$random(seed), $random(seed)});
    if (op == `ATARSC_OP_RD28)
      base[47:28] = 20'h0;
    nsec = 0;
    nword = 0;
    err_idx = eidx;
    @(posedge core_clk);
    cmd_valid <= 1'b1;
    cmd_op <= op;
    cmd_lba <= base;
    cmd_count <= cnt;
    @(posedge core_clk);
    cmd_valid <= 1'b0;
    while (done !== 1'b1 && t < 30000) begin
      @(posedge core_clk);
      #1;
      t++;
    end
    // Let the last word's monitor edge land before counting
    @(posedge core_clk);
    #1;
    if (ck(t >= 30000)) bad("no completion");
    if (ck(nsec !== nexp)) bad("sector count");
    if (ck(nword !== 256 * nexp)) bad("word count");
    if (ck(done_status[0] !== (eidx >= 0))) bad("error bit");
    if (ck(done_status[7] !== 1'b0)) bad("still busy");
    if (ck(cmd_ready !== 1'b1)) bad("host not idle");
    $display("test op %h done", op);
  endtask
  task automatic test_done;
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  initial begin
    seed = 32'h4699;
    n_fail = 0;
    n_checks = 0;
    {nsec, nword, err_idx, base} = '0;
    {cmd_valid, cmd_op, cmd_lba, cmd_count} = '0;
    {media_valid, media_data, media_err} = '0;
    native_max = 48'({$random(seed), $random(seed)});
    sys_rst = 1'b1;
    repeat (20) @(posedge core_clk);
    sys_rst <= 1'b0;
    run(`ATARSC_OP_NMAX28, 16'h0000, -1, 0);
    if (ck(result_lba !== {20'h0, native_max[27:0]})) bad("max28");
    run(`ATARSC_OP_NMAX48, 16'h0000, -1, 0);
    if (ck(result_lba !== native_max)) bad("max48");
    run(`ATARSC_OP_RD28, 16'h0002, -1, 2);
    run(`ATARSC_OP_RD48, 16'h0002, -1, 2);
    run(`ATARSC_OP_RD28, 16'h0000, 3, 4);
    run(`ATARSC_OP_RD48, 16'h0003, 1, 2);
    test_done;
  end
  // About three and a half times the expected run length
  initial begin
    #1000000;
    n_fail++;
    test_done;
  end
endmodule
